/* File: sdwl_pkg.sv */
// Functional notes
// - Each of the first 24 falling serial clock edges in a frame shifts in one bit; later edges are ignored.
// - Frame select is active low and level sensitive; low enables shifting.
// - On the 24th falling edge with select still low, the DAC is updated.
// - Select rising before the 24th edge aborts: word dropped, no update.
// - The DAC code is 16-bit straight binary, zeros zero scale, ones full.
// - Two mode bits pick normal, three-state, 100 k or 1 k to ground.
// - The 16 bits after the mode bits go to the DAC register on edge 24.
// - Power-down mode words still load their 16 bits into the DAC register.
package sdwl_pkg;
    localparam int FRAME_BITS = 24;
    localparam int CODE_BITS = 16;
    localparam int CODE_LSB = 0;
    localparam int MODE_LSB = 16;
    localparam int CNT_BITS = 5;
    localparam logic [CNT_BITS-1:0] LAST_BIT = 5'h17;
    localparam logic [15:0] CODE_RESET = 16'h0000;
    localparam int SCLK_MAX_MHZ = 30;
    localparam int SYNC_HIGH_NS = 12;

    typedef enum logic [1:0] {
        SDWL_MODE_NORMAL,
        SDWL_MODE_TRISTATE,
        SDWL_MODE_100K,
        SDWL_MODE_1K
    } sdwl_mode_t;

    typedef struct packed {
        sdwl_mode_t mode;
        logic [CODE_BITS-1:0] code;
    } sdwl_word_t;
endpackage

/* File: sdwl_link.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Link side shifter on the serial clock
// ----------------------------------------
module sdwl_link
    import sdwl_pkg::*;
(
    input wire logic sclk,                  // Serial clock
    input wire logic sync_n,                // Frame select, low active
    input wire logic din,                   // Serial data
    output sdwl_pkg::sdwl_word_t word,      // Captured word
    output logic done_tgl                   // Toggles per full frame
);
    logic [FRAME_BITS-1:0] shreg;
    logic [CNT_BITS-1:0] cnt;
    logic full;
    logic tgl = 1'b0;

    assign done_tgl = tgl;

    // Frame select high clears state asynchronously: abort or re-arm
    always_ff @(negedge sclk or posedge sync_n)
    begin
        if (sync_n)
        begin
            cnt <= '0;
            full <= 1'b0;
        end
        else if (!full)
        begin
            if (cnt == LAST_BIT)
                full <= 1'b1;
            cnt <= cnt + 5'h01;
        end
    end

    always_ff @(negedge sclk)
    begin
        if (!sync_n && !full)
            shreg <= {shreg[FRAME_BITS-2:0], din};
    end

    // Word and event leave on the 24th edge only
    always_ff @(negedge sclk)
    begin
        if (!sync_n && !full && cnt == LAST_BIT)
        begin
            word <= sdwl_word_t'({shreg[MODE_LSB:0], din});
            tgl <= ~tgl;
        end
    end
endmodule

/* File: sdwl_top.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Serial DAC word loader, system side
// ----------------------------------------
module sdwl_top
    import sdwl_pkg::*;
(
    input wire logic CLK_SYS,                // System clock
    input wire logic RST,                    // Sync reset, high
    input wire logic SCLK,                   // Serial clock
    input wire logic SYNC_N,                 // Frame select
    input wire logic DIN,                    // Serial data
    output logic [15:0] DAC_CODE,            // DAC register
    output sdwl_pkg::sdwl_mode_t OUT_MODE,   // Output mode
    output logic UPDATE                      // One-cycle update pulse
);
    import sdwl_pkg::*;


    // ----------------------------------------
    // Internal signals
    // ----------------------------------------
    // Frames must lie well over eight system cycles apart; at the
    // highest serial rate a frame lasts far longer, so the crossing
    // below never sees two toggles in flight.
    sdwl_word_t word;
    logic done_tgl;
    logic [2:0] tgl_sync;
    logic tgl_seen;
    logic frame_evt;
    sdwl_word_t held_word;
    logic chk_pend;
    logic word_same;
    logic load_pend;
    logic [15:0] next_code;
    sdwl_mode_t next_mode;
    logic next_update;

    // ----------------------------------------
    // Helper functions
    // ----------------------------------------
    // Stages two and three hold the same level
    function automatic logic tgl_agree(input logic [2:0] chain);
        return chain[2] == chain[1];
    endfunction

    // Settled level that has not been acted on yet
    function automatic logic tgl_event(
        input logic [2:0] chain,
        input logic seen
    );
        return tgl_agree(chain) && (chain[2] != seen);
    endfunction

    function automatic logic [15:0] code_of(input sdwl_word_t w);
        return w.code;
    endfunction

    function automatic sdwl_mode_t mode_of(input sdwl_word_t w);
        return w.mode;
    endfunction

    // ----------------------------------------
    // Serial clock domain
    // ----------------------------------------
    sdwl_link u_link (
        .sclk(SCLK),
        .sync_n(SYNC_N),
        .din(DIN),
        .word(word),
        .done_tgl(done_tgl)
    );

    // ----------------------------------------
    // Toggle synchroniser
    // ----------------------------------------
    // Runs through reset so the chain has settled when reset ends
    always_ff @(posedge CLK_SYS)
    begin
        tgl_sync <= {tgl_sync[1:0], done_tgl};
    end

    assign frame_evt = tgl_event(tgl_sync, tgl_seen);

    // ----------------------------------------
    // Level already acted on
    // ----------------------------------------
    // Reset adopts the settled level, so no false frame follows reset
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            tgl_seen <= tgl_sync[2];
        end
        else if (frame_evt)
        begin
            tgl_seen <= tgl_sync[2];
        end
    end

    // ----------------------------------------
    // Word capture
    // ----------------------------------------
    // Link word holds until the next frame's 24th edge
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            held_word <= sdwl_word_t'({SDWL_MODE_NORMAL, CODE_RESET});
        end
        else if (frame_evt || (chk_pend && !word_same))
        begin
            held_word <= word;
        end
    end

    assign word_same = (held_word == word);

    // ----------------------------------------
    // Capture check
    // ----------------------------------------
    // Second look one cycle later; a moving word is taken again
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            chk_pend <= 1'b0;
        end
        else if (frame_evt)
        begin
            chk_pend <= 1'b1;
        end
        else if (word_same)
        begin
            chk_pend <= 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            load_pend <= 1'b0;
        end
        else
        begin
            load_pend <= chk_pend && word_same;
        end
    end

    // ----------------------------------------
    // Next DAC code
    // ----------------------------------------
    always_comb
    begin
        next_code = DAC_CODE;
        if (load_pend)
        begin
            next_code = code_of(held_word);
        end
    end

    // ----------------------------------------
    // Next output mode
    // ----------------------------------------
    always_comb
    begin
        next_mode = OUT_MODE;
        if (load_pend)
        begin
            next_mode = mode_of(held_word);
        end
    end

    // ----------------------------------------
    // Next update pulse
    // ----------------------------------------
    always_comb
    begin
        next_update = load_pend;
    end

    // ----------------------------------------
    // DAC register
    // ----------------------------------------
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            DAC_CODE <= CODE_RESET;
        end
        else
        begin
            DAC_CODE <= next_code;
        end
    end

    // ----------------------------------------
    // Output mode
    // ----------------------------------------
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            OUT_MODE <= SDWL_MODE_NORMAL;
        end
        else
        begin
            OUT_MODE <= next_mode;
        end
    end

    // ----------------------------------------
    // Update pulse
    // ----------------------------------------
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            UPDATE <= 1'b0;
        end
        else
        begin
            UPDATE <= next_update;
        end
    end
endmodule

/* File: sdwl_asserts.sv */
`timescale 1ns/1ps
module sdwl_asserts
    import sdwl_pkg::*;
(
    input wire logic CLK_SYS, // Clock
    input wire logic RST, // Reset
    input wire logic SYNC_N, // Select
    input wire logic [15:0] DAC_CODE, // Code
    input wire sdwl_pkg::sdwl_mode_t OUT_MODE, // Mode
    input wire logic UPDATE // Pulse
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    sequence idle_s; SYNC_N [*8]; endsequence
    code_hold_a: assert property (!UPDATE |-> $stable(DAC_CODE))
        else $error("code moved");
    mode_hold_a: assert property (!UPDATE |-> $stable(OUT_MODE))
        else $error("mode moved");
    upd_gap_a: assert property (UPDATE |=> !UPDATE [*8])
        else $error("update repeats");
    abort_quiet_a: assert property (idle_s |-> !UPDATE)
        else $error("update while idle");
    sel_low_a: assert property (UPDATE |-> !$past(SYNC_N, 8))
        else $error("update outside frame");
    rst_code_a: assert property ($fell(RST) |-> ~|DAC_CODE)
        else $error("code not cleared");
    rst_mode_a: assert property ($fell(RST) |-> ~|OUT_MODE)
        else $error("mode not cleared");
    pd_hold_a: assert property (
        |OUT_MODE && !UPDATE |-> $stable(DAC_CODE)) else $error("pd code");
endmodule
bind sdwl_top sdwl_asserts chk_u (.*);

/* File: sdwl_host.sv */
`timescale 1ns/1ps
module sdwl_host
(
    output logic sclk = 1'b1, // Clock
    output logic sync_n = 1'b0, // Select
    output logic din = 1'b0 // Data
);
    // Rising select at start clears the link state
    initial #1 sync_n = 1'b1;
    // Sends n bits MSB first; clock idles high between frames
    task automatic send(input logic [31:0] v, input int n);
        #3 sync_n = 1'b0;
        for (int i = 31; i > 31 - n; i--)
        begin
            din = v[i];
            #6 sclk = 1'b0;
            #6 sclk = 1'b1;
        end
        #3 sync_n = 1'b1;
        din = ~din;
        #12;
    endtask
endmodule

/* File: tb.sv */
`timescale 1ns/1ps
module tb;
    import sdwl_pkg::*;
    `define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin \
        miscompares++; $display("[FAIL] %0t %h %h", $time, a, b); end end
    logic clk = 1'b0, rst = 1'b1, sclk, sync_n, din, upd;
    logic [15:0] code;
    sdwl_mode_t mode;
    logic [31:0] w;
    int miscompares = 0, tests_run = 0, ups = 0, ticks = 0;
    sdwl_top dut_u (.CLK_SYS(clk), .RST(rst), .SCLK(sclk), .SYNC_N(sync_n),
        .DIN(din), .DAC_CODE(code), .OUT_MODE(mode), .UPDATE(upd));
    sdwl_host host_u (.sclk(sclk), .sync_n(sync_n), .din(din));
    initial forever #4 clk = ~clk;
    always @(posedge clk) ups <= ups + int'(upd === 1'b1);
    always @(posedge clk) if (++ticks > 4000) give_verdict(1);
    function automatic logic [17:0] want(input logic [31:0] v);
        return v[25:8];
    endfunction
    task automatic give_verdict(input int hang);
        miscompares += hang;
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        void'($urandom(41));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        `CHK({mode, code}, 18'h00000)
        for (int m = 0; m < 6; m++)
        begin
            if (m != 4)
                w = $urandom;
            if (m < 4)
                w[25:24] = 2'(m);
            if (m < 2)
                w[23:8] = {16{m[0]}};
            host_u.send(m == 4 ? ~w : w, m == 4 ? 23 : (m == 5 ? 30 : 24));
            repeat (8) @(posedge clk);
            `CHK(ups, m + int'(m < 4))
            `CHK({mode, code}, want(w))
        end
        give_verdict(0);
    end
endmodule
